// ---- logic/rukg_pkg.sv ----
// package: register map, field values and constants of the unprotect key guard
package rukg_pkg;
	localparam int RUKG_KEY_BYTES = 8;
	// register byte addresses
	localparam logic [7:0] RUKG_OFS_KEY_LO = 8'h00;
	localparam logic [7:0] RUKG_OFS_KEY_HI = 8'h04;
	localparam logic [7:0] RUKG_OFS_CFG = 8'h08;
	localparam logic [7:0] RUKG_OFS_FAILCNT = 8'h0c;
	localparam logic [7:0] RUKG_OFS_LOADER = 8'h10;
	localparam logic [7:0] RUKG_OFS_TRY_LO = 8'h14;
	localparam logic [7:0] RUKG_OFS_TRY_HI = 8'h18;
	localparam logic [7:0] RUKG_OFS_STATUS = 8'h1c;
	localparam logic [7:0] RUKG_OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] RUKG_OFS_IRQ_MASK = 8'h24;
	// field values
	localparam logic [3:0] RUKG_TMU_DISABLED = 4'h5;
	localparam logic [3:0] RUKG_CFG_RESET = 4'h5;
	localparam logic [7:0] RUKG_FAIL_LIMIT = 8'h08;
	localparam logic [7:0] RUKG_LOADER_ON = 8'h55;
	localparam logic [7:0] RUKG_LOADER_ON_N = 8'haa;
	localparam logic [7:0] RUKG_BYTE_ZERO = 8'h00;
	localparam logic [7:0] RUKG_BYTE_ONES = 8'hff;
	localparam logic [31:0] RUKG_KEY_RESET = 32'h0;
	localparam logic [7:0] RUKG_FAIL_RESET = 8'h00;
	// erase strobe length in cycles
	localparam int RUKG_ERASE_CYCLES = 4;
	// status bit positions
	localparam int RUKG_ST_UNLOCKED = 0;
	localparam int RUKG_ST_ERASED = 1;
	localparam int RUKG_ST_LOADER = 2;
	localparam int RUKG_ST_KEYBAD = 3;
	localparam int RUKG_ST_ENABLED = 4;
	localparam int RUKG_ST_BUSY = 5;
	// interrupt bits
	localparam int RUKG_IRQ_FAIL = 0;
	localparam int RUKG_IRQ_UNLOCK = 1;
	localparam int RUKG_IRQ_ERASE = 2;
	localparam int RUKG_IRQ_BITS = 3;
	typedef enum logic [1:0] {
		RUKG_IDLE,
		RUKG_COMPARE,
		RUKG_DONE
	} rukg_cmp_state_type;
endpackage

// ---- logic/rukg_cmp_if.sv ----
// interface: key comparison request and result between guard and comparator
`timescale 1ns/1ps
`default_nettype none
interface rukg_cmp_if;
	logic start;
	logic [63:0] stored_key;
	logic [63:0] try_key;
	logic done;
	logic match;
	modport guard (output start, output stored_key, output try_key,
		input done, input match);
	modport cmp (input start, input stored_key, input try_key,
		output done, output match);
endinterface
`default_nettype wire

// ---- logic/rukg_key_cmp.sv ----
// module: byte-serial comparator of presented key against stored key
`timescale 1ns/1ps
`default_nettype none
module rukg_key_cmp
	import rukg_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	rukg_cmp_if.cmp cmp
);
	rukg_cmp_state_type state;
	logic [2:0] idx;
	logic all_equal;
	logic done;

	function automatic logic byte_eq(input logic [63:0] a,
		input logic [63:0] b, input logic [2:0] i);
		byte_eq = (a[i*8 +: 8] == b[i*8 +: 8]);
	endfunction

	// one byte per cycle; a single mismatch fails the whole attempt
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= RUKG_IDLE;
			idx <= 3'h0;
			all_equal <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				RUKG_IDLE: begin
					if (cmp.start) begin
						idx <= 3'h0;
						all_equal <= 1'b1;
						state <= RUKG_COMPARE;
					end
				end
				RUKG_COMPARE: begin
					if (!byte_eq(cmp.stored_key, cmp.try_key, idx)) begin
						all_equal <= 1'b0;
					end
					if (idx == 3'(RUKG_KEY_BYTES - 1)) begin
						state <= RUKG_DONE;
					end
					idx <= idx + 3'h1;
				end
				default: begin
					done <= 1'b1;
					state <= RUKG_IDLE;
				end
			endcase
		end
	end

	assign cmp.done = done;
	assign cmp.match = all_equal;
endmodule
`default_nettype wire

// ---- logic/rukg_erase_pulse.sv ----
// module: erase strobe generator for program flash and data eeprom
`timescale 1ns/1ps
`default_nettype none
module rukg_erase_pulse
	import rukg_pkg::*;
#(
	parameter int CYCLES = RUKG_ERASE_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_fire,
	output logic o_busy
);
	logic [7:0] count;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count <= 8'h00;
		end else if (i_fire && count == 8'h00) begin
			count <= 8'(CYCLES);
		end else if (count != 8'h00) begin
			count <= count - 8'h01;
		end
	end

	assign o_busy = (count != 8'h00);
endmodule
`default_nettype wire

// ---- logic/rukg_guard.sv ----
// top module: readout unprotect key guard with apb register access
//
// Operation
// - counter preset only while enable field 0101
// - wrong key increments counter when enabled
// - counter at eight erases flash and eeprom
// - loader bytes 55/aa force loader start
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rukg_guard
	import rukg_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_readout_unlocked,
	output logic o_erase_flash,
	output logic o_erase_eeprom,
	output logic o_loader_force,
	output logic o_irq
);
	logic [31:0] key_lo;
	logic [31:0] key_hi;
	logic [3:0] temporary_unprotect_enable;
	logic [7:0] failed_attempt_counter;
	logic [7:0] loader_enable;
	logic [7:0] loader_enable_n;
	logic [31:0] try_lo;
	logic [31:0] try_hi;
	logic unlocked;
	logic erased;
	logic start;
	logic [RUKG_IRQ_BITS-1:0] irq_stat;
	logic [RUKG_IRQ_BITS-1:0] irq_mask;
	logic [RUKG_IRQ_BITS-1:0] irq_set;
	logic wr;
	logic rd;
	logic mapped;
	logic enabled;
	logic key_bad;
	logic fail_evt;
	logic pass_evt;
	logic erase_evt;
	logic erase_busy;
	logic [31:0] next_prdata;

	rukg_cmp_if cmp_bus ();

	function automatic logic byte_illegal(input logic [7:0] b);
		byte_illegal = (b == RUKG_BYTE_ZERO) || (b == RUKG_BYTE_ONES);
	endfunction

	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;
	assign enabled = (temporary_unprotect_enable != RUKG_TMU_DISABLED);

	always_comb begin
		key_bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (byte_illegal(key_lo[i*8 +: 8]) ||
				byte_illegal(key_hi[i*8 +: 8])) begin
				key_bad = 1'b1;
			end
		end
	end

	always_comb begin
		mapped = 1'b1;
		next_prdata = 32'h0;
		if (i_paddr == RUKG_OFS_KEY_LO) begin
			next_prdata = key_lo;
		end else if (i_paddr == RUKG_OFS_KEY_HI) begin
			next_prdata = key_hi;
		end else if (i_paddr == RUKG_OFS_CFG) begin
			next_prdata = {28'h0, temporary_unprotect_enable};
		end else if (i_paddr == RUKG_OFS_FAILCNT) begin
			next_prdata = {24'h0, failed_attempt_counter};
		end else if (i_paddr == RUKG_OFS_LOADER) begin
			next_prdata = {16'h0, loader_enable_n, loader_enable};
		end else if (i_paddr == RUKG_OFS_TRY_LO) begin
			next_prdata = 32'h0;
		end else if (i_paddr == RUKG_OFS_TRY_HI) begin
			next_prdata = 32'h0;
		end else if (i_paddr == RUKG_OFS_STATUS) begin
			next_prdata[RUKG_ST_UNLOCKED] = unlocked;
			next_prdata[RUKG_ST_ERASED] = erased;
			next_prdata[RUKG_ST_LOADER] = o_loader_force;
			next_prdata[RUKG_ST_KEYBAD] = key_bad;
			next_prdata[RUKG_ST_ENABLED] = enabled;
			next_prdata[RUKG_ST_BUSY] = start || erase_busy;
		end else if (i_paddr == RUKG_OFS_IRQ_STAT) begin
			next_prdata = {29'h0, irq_stat};
		end else if (i_paddr == RUKG_OFS_IRQ_MASK) begin
			next_prdata = {29'h0, irq_mask};
		end else begin
			mapped = 1'b0;
		end
	end

	// combinational read data keeps the zero-wait answer in the same cycle
	assign o_prdata = rd ? next_prdata : 32'h0;
	assign o_pslverr = i_psel && i_penable && !mapped;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			key_lo <= RUKG_KEY_RESET;
			key_hi <= RUKG_KEY_RESET;
			temporary_unprotect_enable <= RUKG_CFG_RESET;
			loader_enable <= RUKG_FAIL_RESET;
			loader_enable_n <= RUKG_FAIL_RESET;
			irq_mask <= '0;
		end else if (wr) begin
			if (i_paddr == RUKG_OFS_KEY_LO) begin
				key_lo <= i_pwdata;
			end else if (i_paddr == RUKG_OFS_KEY_HI) begin
				key_hi <= i_pwdata;
			end else if (i_paddr == RUKG_OFS_CFG) begin
				temporary_unprotect_enable <= i_pwdata[3:0];
			end else if (i_paddr == RUKG_OFS_LOADER) begin
				loader_enable <= i_pwdata[7:0];
				loader_enable_n <= i_pwdata[15:8];
			end else if (i_paddr == RUKG_OFS_IRQ_MASK) begin
				irq_mask <= i_pwdata[RUKG_IRQ_BITS-1:0];
			end
		end
	end

	// writing the high word of a presented key launches the attempt, only while enabled and no erase strobe is running
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			try_lo <= RUKG_KEY_RESET;
			try_hi <= RUKG_KEY_RESET;
			start <= 1'b0;
		end else begin
			start <= 1'b0;
			if (wr && i_paddr == RUKG_OFS_TRY_LO) begin
				try_lo <= i_pwdata;
			end
			if (wr && i_paddr == RUKG_OFS_TRY_HI && enabled &&
				!erase_busy) begin
				try_hi <= i_pwdata;
				start <= 1'b1;
			end
		end
	end

	assign cmp_bus.start = start;
	assign cmp_bus.stored_key = {key_hi, key_lo};
	assign cmp_bus.try_key = {try_hi, try_lo};

	rukg_key_cmp u_cmp (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.cmp(cmp_bus)
	);

	assign fail_evt = cmp_bus.done && !cmp_bus.match && enabled;
	assign pass_evt = cmp_bus.done && cmp_bus.match && enabled;
	assign erase_evt = fail_evt &&
		(failed_attempt_counter + 8'h01 == RUKG_FAIL_LIMIT);

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			failed_attempt_counter <= RUKG_FAIL_RESET;
		end else if (fail_evt) begin
			failed_attempt_counter <= failed_attempt_counter + 8'h01;
		end else if (wr && i_paddr == RUKG_OFS_FAILCNT && !enabled) begin
			failed_attempt_counter <= i_pwdata[7:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			unlocked <= 1'b0;
			erased <= 1'b0;
		end else begin
			if (erase_evt) begin
				erased <= 1'b1;
				unlocked <= 1'b0;
			end else if (pass_evt) begin
				unlocked <= 1'b1;
			end else if (!enabled) begin
				unlocked <= 1'b0;
			end
		end
	end

	rukg_erase_pulse u_erase (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_fire(erase_evt),
		.o_busy(erase_busy)
	);

	assign o_erase_flash = erase_busy;
	assign o_erase_eeprom = erase_busy;
	assign o_readout_unlocked = unlocked;
	assign o_loader_force = (loader_enable == RUKG_LOADER_ON) &&
		(loader_enable_n == RUKG_LOADER_ON_N);

	always_comb begin
		irq_set = '0;
		irq_set[RUKG_IRQ_FAIL] = fail_evt;
		irq_set[RUKG_IRQ_UNLOCK] = pass_evt;
		irq_set[RUKG_IRQ_ERASE] = erase_evt;
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_stat <= '0;
		end else if (wr && i_paddr == RUKG_OFS_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~i_pwdata[RUKG_IRQ_BITS-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	assign o_irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// ---- dv/rukg_guard_checker.sv ----
// checker: port-level assertions of the unprotect key guard
`timescale 1ns/1ps
`default_nettype none
module rukg_guard_checker
	import rukg_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_readout_unlocked,
	input wire logic o_erase_flash,
	input wire logic o_erase_eeprom,
	input wire logic o_loader_force,
	input wire logic o_irq
);
	logic acc;
	logic [5:0] since;
	assign acc = i_psel & i_penable;
	// cycles since the last write to the high try word, launching or not, saturating
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst)
			since <= 6'h3f;
		else if (acc & i_pwrite & (i_paddr == RUKG_OFS_TRY_HI))
			since <= 6'h00;
		else if (since != 6'h3f)
			since <= since + 6'h01;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence erase_run;
		o_erase_flash [*4] ##1 !o_erase_flash;
	endsequence
	chk_ready_high: assert property (o_pready)
		else $error("pready low");
	chk_slverr_map: assert property (acc && i_paddr[1:0] == 2'h0
		|-> o_pslverr == (i_paddr > RUKG_OFS_IRQ_MASK))
		else $error("pslverr wrong");
	chk_prdata_idle: assert property (!(acc && !i_pwrite) |-> o_prdata == 32'h0)
		else $error("prdata not zero");
	chk_erase_len: assert property ($rose(o_erase_flash) |-> erase_run)
		else $error("erase length wrong");
	chk_erase_both: assert property (o_erase_flash == o_erase_eeprom)
		else $error("erase outputs differ");
	chk_erase_cause: assert property ($rose(o_erase_flash)
		|-> since inside {[6:18]}) else $error("erase without attempt");
	chk_unlock_cause: assert property ($rose(o_readout_unlocked)
		|-> since inside {[6:16]}) else $error("unlock without attempt");
	chk_loader_src: assert property ($changed(o_loader_force)
		|-> $past(acc & i_pwrite & (i_paddr == RUKG_OFS_LOADER)))
		else $error("loader force changed alone");
	chk_irq_masked: assert property (acc && i_pwrite && i_pwdata == 32'h0
		&& i_paddr == RUKG_OFS_IRQ_MASK |=> !o_irq)
		else $error("irq with zero mask");
endmodule
`default_nettype wire

// ---- dv/rukg_host.sv ----
// partner: apb host presenting keys and register accesses
`timescale 1ns/1ps
`default_nettype none
module rukg_host (
	input wire logic i_sys_clk,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr,
	output logic o_psel = 1'b0,
	output logic o_penable = 1'b0,
	output logic o_pwrite = 1'b0,
	output logic [7:0] o_paddr = 8'h00,
	output logic [31:0] o_pwdata = 32'h0,
	output logic o_hang = 1'b0
);
	function automatic logic [63:0] legal_key();
		logic [63:0] k;
		for (int i = 0; i < 8; i++)
			k[8*i +: 8] = 8'h01 + 8'($urandom % 254);
		return k;
	endfunction
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge i_sys_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_sys_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 32);
		if (i_pready !== 1'b1)
			o_hang <= 1'b1;
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// released data lines do not keep the last value
		o_pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// testbench: scenario run against a reference model of the key guard
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rukg_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_psel;
	logic i_penable;
	logic i_pwrite;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic o_readout_unlocked;
	logic o_erase_flash;
	logic o_erase_eeprom;
	logic o_loader_force;
	logic o_irq;
	logic hang;
	logic [31:0] rdat;
	logic rerr;
	logic [63:0] mkey;
	logic [15:0] ltab [3] = '{16'haa55, 16'hab55, 16'haa54};
	int mismatches = 0;
	int compares = 0;
	int mcnt = RUKG_FAIL_RESET;
	int ecnt = 0;
	bit en = 0;
	always #12.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk)
		if (o_erase_flash === 1'b1 && o_erase_eeprom === 1'b1)
			ecnt++;
	rukg_guard DUT (.i_sys_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.o_readout_unlocked, .o_erase_flash, .o_erase_eeprom,
		.o_loader_force, .o_irq);
	rukg_host host (.i_sys_clk, .i_prdata(o_prdata), .i_pready(o_pready),
		.i_pslverr(o_pslverr), .o_psel(i_psel), .o_penable(i_penable),
		.o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata),
		.o_hang(hang));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge hang) begin
		mismatches++;
		test_done();
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdat, rerr);
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, rdat, rerr);
	endtask
	// attempt, model update, then counter read back
	task automatic att(input logic [63:0] k);
		wr(RUKG_OFS_TRY_LO, k[31:0]);
		wr(RUKG_OFS_TRY_HI, k[63:32]);
		if (en && k !== mkey)
			mcnt++;
		repeat (16) @(posedge i_sys_clk);
		rd(RUKG_OFS_FAILCNT);
	endtask
	initial begin
		void'($urandom(2507));
		mkey = host.legal_key();
		repeat (6) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		rd(RUKG_OFS_CFG);
		check(rdat, RUKG_CFG_RESET);
		rd(RUKG_OFS_FAILCNT);
		check(rdat, RUKG_FAIL_RESET);
		rd(8'h28);
		check({rerr, rdat}, {1'b1, 32'h0});
		$display("test reset done");
		wr(RUKG_OFS_FAILCNT, 32'h5);
		if (!en)
			mcnt = 5;
		wr(RUKG_OFS_KEY_LO, mkey[31:0]);
		wr(RUKG_OFS_KEY_HI, mkey[63:32]);
		att(mkey ^ 64'h1);
		check(rdat, 64'(mcnt));
		wr(RUKG_OFS_CFG, 32'ha);
		en = 1;
		wr(RUKG_OFS_FAILCNT, 32'h1);
		rd(RUKG_OFS_FAILCNT);
		check(rdat, 64'(mcnt));
		$display("test preset done");
		att(mkey);
		check({o_readout_unlocked, rdat}, {1'b1, 32'(mcnt)});
		rd(RUKG_OFS_IRQ_STAT);
		check(rdat, 32'h1 << RUKG_IRQ_UNLOCK);
		wr(RUKG_OFS_IRQ_MASK, 32'h2);
		@(posedge i_sys_clk);
		check(o_irq, 1'b1);
		wr(RUKG_OFS_IRQ_MASK, 32'h0);
		@(posedge i_sys_clk);
		check(o_irq, 1'b0);
		wr(RUKG_OFS_IRQ_MASK, 32'h7);
		wr(RUKG_OFS_IRQ_STAT, 32'h2);
		@(posedge i_sys_clk);
		check(o_irq, 1'b0);
		$display("test unlock done");
		for (int i = 0; i < 3; i++) begin
			att(mkey ^ (64'h1 << (8 * ($urandom % 8))));
			check(rdat, 64'(mcnt));
			check(ecnt, (mcnt == 8) ? 4 : 0);
		end
		rd(RUKG_OFS_IRQ_STAT);
		check({o_irq, o_readout_unlocked, rdat}, {2'b10, 32'h5});
		$display("test failures done");
		for (int i = 0; i < 3; i++) begin
			wr(RUKG_OFS_LOADER, {16'h0, ltab[i]});
			@(posedge i_sys_clk);
			check(o_loader_force, i == 0);
		end
		$display("test loader done");
		// mid-run reset clears pending interrupt and the counter
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		check({o_irq, o_readout_unlocked, o_erase_flash}, 3'h0);
		i_nrst <= 1'b1;
		rd(RUKG_OFS_FAILCNT);
		check(rdat, RUKG_FAIL_RESET);
		rd(RUKG_OFS_CFG);
		check(rdat, RUKG_CFG_RESET);
		$display("test second reset done");
		test_done();
	end
endmodule
bind rukg_guard rukg_guard_checker chk (.i_sys_clk, .i_nrst, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
	.o_pslverr, .o_readout_unlocked, .o_erase_flash, .o_erase_eeprom,
	.o_loader_force, .o_irq);
`default_nettype wire
